// File: src_pkg.sv
// Package for the skip field decoder and repeat counter.
// Assumes a single processor clock; all widths and codes live here.
package src_pkg;

    // Field and bus widths
    localparam int SKIP_W   = 4;
    localparam int CNT_W    = 4;
    localparam int SBUS_W   = 16;
    localparam int TBUS_W   = 16;

    // Skip field codes
    localparam logic [SKIP_W-1:0] INCREMENT_ONLY_CODE    = 4'h0;
    localparam logic [SKIP_W-1:0] REPEAT_MODE_CODE       = 4'h1;
    localparam logic [SKIP_W-1:0] OVERFLOW_SKIP_CODE     = 4'h5;
    localparam logic [SKIP_W-1:0] RESULT_ZERO_SKIP_CODE  = 4'h7;
    localparam logic [SKIP_W-1:0] TEST_INCREMENT_CODE    = 4'h8;
    localparam logic [SKIP_W-1:0] COUNT_FULL_SKIP_CODE   = 4'h9;
    localparam logic [SKIP_W-1:0] ALWAYS_SKIP_CODE       = 4'he;
    localparam logic [SKIP_W-1:0] NO_OPERATION_CODE      = 4'hf;

    // Reset values and counter constants
    localparam logic [CNT_W-1:0]  CNT_RESET   = 4'h0;
    localparam logic [CNT_W-1:0]  CNT_ONE     = 4'h1;
    localparam logic [CNT_W-1:0]  CNT_FULL    = 4'hf;
    localparam logic              FLAG_RESET  = 1'b0;

    // Synchroniser depth for the second-phase clock pin
    localparam int PHASE_SYNC_STAGES = 2;

endpackage

// File: src_skip_decode.sv
// Skip field decoder: turns the four-bit skip field into a skip
// condition, an increment request and a repeat request.
// Assumes all inputs are stable on the processor clock.
`timescale 1ns/100ps
module src_skip_decode
    import src_pkg::*;
(
    input  wire logic [src_pkg::SKIP_W-1:0] skip_field_i,
    input  wire logic                       overflow_i,
    input  wire logic                       tbus_zero_i,
    input  wire logic                       count_full_i,
    output logic                            skip_cond_o,
    output logic                            inc_req_o,
    output logic                            repeat_req_o
);

    // Condition per code; unlisted codes belong to other decoders
    always_comb
    begin
        skip_cond_o  = 1'b0;
        inc_req_o    = 1'b0;
        repeat_req_o = 1'b0;
        case (skip_field_i)
            OVERFLOW_SKIP_CODE:    skip_cond_o = overflow_i;
            RESULT_ZERO_SKIP_CODE: skip_cond_o = tbus_zero_i;
            ALWAYS_SKIP_CODE:      skip_cond_o = 1'b1;
            REPEAT_MODE_CODE:      repeat_req_o = 1'b1;
            INCREMENT_ONLY_CODE:   inc_req_o = 1'b1;
            COUNT_FULL_SKIP_CODE:  skip_cond_o = count_full_i;
            TEST_INCREMENT_CODE:
            begin
                // Test reads the pre-increment carry
                skip_cond_o = count_full_i;
                inc_req_o   = 1'b1;
            end
            NO_OPERATION_CODE:     skip_cond_o = 1'b0;
            default:               skip_cond_o = 1'b0;
        endcase
    end

endmodule

// File: src_counter.sv
// Repeat counter: four-bit binary counter plus a fifth-bit flag.
// Assumes step_i is a one-cycle pulse marking the second-phase edge.
`timescale 1ns/100ps
module src_counter
    import src_pkg::*;
#(
    parameter int WIDTH = src_pkg::CNT_W
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             step_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] load_data_i,
    input  wire logic             inc_i,
    output logic      [WIDTH-1:0] count_o,
    output logic                  fifth_o,
    output logic                  carry_o
);

    // Carry is true while the low bits are all ones
    assign carry_o = &count_o;

    // Low four bits; load beats increment
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            count_o <= WIDTH'(CNT_RESET);
        else if (step_i && load_i)
            count_o <= load_data_i;
        else if (step_i && inc_i)
            count_o <= count_o + WIDTH'(CNT_ONE);
    end

    // Fifth bit: set by carry ANDed with increment, cleared by load
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            fifth_o <= FLAG_RESET;
        else if (step_i && load_i)
            fifth_o <= 1'b0;
        else if (step_i && inc_i && carry_o)
            fifth_o <= 1'b1;
    end

endmodule

// File: src_skip_repeat.sv
// Skip condition logic and repeat counter for a microprogrammed core.
// Assumes microinstruction fields are stable at each second-phase
// falling edge, which marks one microcycle; the phase clock is a pin.
//
// Function
// - Overflow code skips the next microinstruction when the overflow flag is set.
// - Repeat code re-executes the next microinstruction until its own skip holds.
// - Zero-test code skips the next microinstruction when the T-bus is zero.
// - Always-skip code skips the next microinstruction unconditionally.
// - No-operation code causes no skip, repeat or counter action.
// - Counter is four binary bits plus a separate fifth-bit flip-flop.
// - Special counter code loads the counter from S-bus bits 0-3 on phase two.
// - Either increment code adds one on the phase-two edge.
// - Increment at all ones sets the fifth bit via carry and increment.
// - Carry output gives the skip for test-only and test-increment codes.
// - Load with no S-bus source clears the counter.
// - Counter select drives all five counter bits onto S-bus bits 0-4.
// - Test-increment tests the pre-increment count, then increments.
// - A skipped word still drives buses but its decode and stores are inhibited.
// - Test codes look at bits 0-3 only; test-increment also increments.
// - Increment-only code adds one and never skips.
`timescale 1ns/100ps
module src_skip_repeat
    import src_pkg::*;
(
    input  wire logic                       MCLK_I,
    input  wire logic                       RST_N_I,
    input  wire logic                       SECOND_PHASE_CLOCK_I,
    input  wire logic [src_pkg::SKIP_W-1:0] SKIP_FIELD_I,
    input  wire logic                       SPECIAL_COUNTER_I,
    input  wire logic                       SBUS_SEL_COUNTER_I,
    input  wire logic                       SBUS_SEL_NONE_I,
    input  wire logic [src_pkg::SBUS_W-1:0] SBUS_I,
    input  wire logic [src_pkg::TBUS_W-1:0] TBUS_I,
    input  wire logic                       OVERFLOW_FLAG_SIGNAL_I,
    output logic                            SKIP_NEXT_O,
    output logic                            REPEAT_ACTIVE_O,
    output logic [src_pkg::CNT_W:0]         SBUS_COUNT_O,
    output logic                            SBUS_COUNT_EN_O,
    output logic                            MICROCYCLE_O
);

    logic [PHASE_SYNC_STAGES-1:0] phase_sync_r;
    logic                         phase_prev_r;
    logic                         step;
    logic                         skip_r;
    logic                         repeat_r;
    logic                         decode_en;
    logic                         skip_cond;
    logic                         inc_req;
    logic                         repeat_req;
    logic                         count_full;
    logic [CNT_W-1:0]             count;
    logic                         fifth;
    logic                         load;
    logic [CNT_W-1:0]             load_data;
    logic [CNT_W:0]               sbus_count_r;
    logic                         sbus_en_r;
    logic                         step_r;

    // Phase clock comes from a pin, so two stages before any use
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            phase_sync_r <= '0;
        else
            phase_sync_r <= {phase_sync_r[PHASE_SYNC_STAGES-2:0], SECOND_PHASE_CLOCK_I};
    end

    // Edge detector reads only the second stage
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            phase_prev_r <= 1'b0;
        else
            phase_prev_r <= phase_sync_r[PHASE_SYNC_STAGES-1];
    end

    // Falling phase-two edge is the counting edge
    assign step = phase_prev_r & ~phase_sync_r[PHASE_SYNC_STAGES-1];

    // A skipped word's fields go undecoded; buses still flow
    assign decode_en = ~skip_r;

    src_skip_decode u_decode
    (
        .skip_field_i (SKIP_FIELD_I),
        .overflow_i   (OVERFLOW_FLAG_SIGNAL_I),
        .tbus_zero_i  (~|TBUS_I),
        .count_full_i (count_full),
        .skip_cond_o  (skip_cond),
        .inc_req_o    (inc_req),
        .repeat_req_o (repeat_req)
    );

    // Load from the S-bus; no source selected means a clear
    assign load      = decode_en & SPECIAL_COUNTER_I;
    assign load_data = SBUS_SEL_NONE_I ? CNT_RESET : SBUS_I[CNT_W-1:0];

    src_counter #(
        .WIDTH (CNT_W)
    ) u_counter
    (
        .clk_i       (MCLK_I),
        .rst_n_i     (RST_N_I),
        .step_i      (step),
        .load_i      (load),
        .load_data_i (load_data),
        .inc_i       (decode_en & inc_req),
        .count_o     (count),
        .fifth_o     (fifth),
        .carry_o     (count_full)
    );

    // Skip for the following word; in repeat mode the condition
    // ends the loop instead, so the last pass still executes
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            skip_r <= 1'b0;
        else if (step)
            skip_r <= decode_en & ~repeat_r & skip_cond;
    end

    // Repeat mode: armed by the repeat code, dropped when the
    // repeated word's own condition is met
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            repeat_r <= 1'b0;
        else if (step && repeat_r && skip_cond)
            repeat_r <= 1'b0;
        else if (step && decode_en && !repeat_r && repeat_req)
            repeat_r <= 1'b1;
    end

    // Counter readback onto S-bus bits 0-4, one clock behind select
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
        begin
            sbus_count_r <= '0;
            sbus_en_r    <= 1'b0;
        end
        else
        begin
            sbus_count_r <= {fifth, count};
            sbus_en_r    <= SBUS_SEL_COUNTER_I;
        end
    end

    // Microcycle marker for the sequencer
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            step_r <= 1'b0;
        else
            step_r <= step;
    end

    assign SKIP_NEXT_O     = skip_r;
    assign REPEAT_ACTIVE_O = repeat_r;
    assign SBUS_COUNT_O    = sbus_count_r;
    assign SBUS_COUNT_EN_O = sbus_en_r;
    assign MICROCYCLE_O    = step_r;

    // Checks on the logic above

    property p_overflow_skip;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !repeat_r && SKIP_FIELD_I == OVERFLOW_SKIP_CODE
        |=> SKIP_NEXT_O == $past(OVERFLOW_FLAG_SIGNAL_I);
    endproperty
    a_overflow_skip: assert property (p_overflow_skip) else $error("overflow skip wrong");

    property p_zero_skip;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !repeat_r && SKIP_FIELD_I == RESULT_ZERO_SKIP_CODE
        |=> SKIP_NEXT_O == ($past(TBUS_I) == '0);
    endproperty
    a_zero_skip: assert property (p_zero_skip) else $error("zero skip wrong");

    property p_always_skip;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !repeat_r && SKIP_FIELD_I == ALWAYS_SKIP_CODE
        |=> SKIP_NEXT_O;
    endproperty
    a_always_skip: assert property (p_always_skip) else $error("unconditional skip missed");

    property p_noop;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && SKIP_FIELD_I == NO_OPERATION_CODE && !SPECIAL_COUNTER_I && !repeat_r
        |=> !SKIP_NEXT_O && $stable(count) && $stable(fifth) && !REPEAT_ACTIVE_O;
    endproperty
    a_noop: assert property (p_noop) else $error("no-op field acted");

    property p_load;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && SPECIAL_COUNTER_I && !SBUS_SEL_NONE_I
        |=> count == $past(SBUS_I[CNT_W-1:0]) && !fifth;
    endproperty
    a_load: assert property (p_load) else $error("counter load wrong");

    property p_clear;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && SPECIAL_COUNTER_I && SBUS_SEL_NONE_I
        |=> count == CNT_RESET && !fifth;
    endproperty
    a_clear: assert property (p_clear) else $error("counter clear wrong");

    property p_increment;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !SPECIAL_COUNTER_I
        && (SKIP_FIELD_I == INCREMENT_ONLY_CODE || SKIP_FIELD_I == TEST_INCREMENT_CODE)
        |=> count == $past(count) + CNT_ONE;
    endproperty
    a_increment: assert property (p_increment) else $error("increment wrong");

    property p_fifth_set;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !SPECIAL_COUNTER_I && count == CNT_FULL
        && (SKIP_FIELD_I == INCREMENT_ONLY_CODE || SKIP_FIELD_I == TEST_INCREMENT_CODE)
        |=> fifth && count == CNT_RESET;
    endproperty
    a_fifth_set: assert property (p_fifth_set) else $error("fifth bit not set");

    property p_test_pre_count;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !repeat_r && !SPECIAL_COUNTER_I
        && SKIP_FIELD_I == TEST_INCREMENT_CODE
        |=> SKIP_NEXT_O == ($past(count) == CNT_FULL);
    endproperty
    a_test_pre_count: assert property (p_test_pre_count) else $error("test used wrong count");

    property p_increment_only_no_skip;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && SKIP_FIELD_I == INCREMENT_ONLY_CODE |=> !SKIP_NEXT_O;
    endproperty
    a_increment_only_no_skip: assert property (p_increment_only_no_skip) else $error("increment skipped");

    property p_repeat_start;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !repeat_r && SKIP_FIELD_I == REPEAT_MODE_CODE
        |=> REPEAT_ACTIVE_O && !SKIP_NEXT_O;
    endproperty
    a_repeat_start: assert property (p_repeat_start) else $error("repeat not entered");

    property p_repeat_end;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && repeat_r && skip_cond |=> !REPEAT_ACTIVE_O ##1 !REPEAT_ACTIVE_O;
    endproperty
    a_repeat_end: assert property (p_repeat_end) else $error("repeat did not end");

    property p_repeat_hold;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        repeat_r && !(step && skip_cond) |=> REPEAT_ACTIVE_O;
    endproperty
    a_repeat_hold: assert property (p_repeat_hold) else $error("repeat dropped early");

    property p_readback;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        SBUS_SEL_COUNTER_I
        |=> SBUS_COUNT_EN_O && SBUS_COUNT_O == {$past(fifth), $past(count)};
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");

    property p_skipped_inert;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && skip_r |=> $stable(count) && $stable(fifth) && !SKIP_NEXT_O;
    endproperty
    a_skipped_inert: assert property (p_skipped_inert) else $error("skipped word decoded");

    property p_count_hold;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        !step |=> $stable(count) && $stable(fifth) && $stable(skip_r);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("state moved off edge");

    // Marker pulse trails the internal step by exactly one clock
    property p_microcycle;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        1'b1 |=> MICROCYCLE_O == $past(step);
    endproperty
    a_microcycle: assert property (p_microcycle) else $error("microcycle marker wrong");

    // Test-only code: skip on full low bits, counter left alone
    property p_count_full_skip;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !repeat_r && !SPECIAL_COUNTER_I && SKIP_FIELD_I == COUNT_FULL_SKIP_CODE
        |=> SKIP_NEXT_O == ($past(count) == CNT_FULL) && $stable(count) && $stable(fifth);
    endproperty
    a_count_full_skip: assert property (p_count_full_skip) else $error("count test wrong");

    // Fifth bit set must not fake a full count
    property p_fifth_ignored;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !repeat_r && SKIP_FIELD_I == COUNT_FULL_SKIP_CODE && fifth && count != CNT_FULL
        |=> !SKIP_NEXT_O;
    endproperty
    a_fifth_ignored: assert property (p_fifth_ignored) else $error("fifth bit tested");

    // Only an increment from a full count may raise the fifth bit
    property p_fifth_quiet;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        step && !skip_r && !fifth && count != CNT_FULL |=> !fifth;
    endproperty
    a_fifth_quiet: assert property (p_fifth_quiet) else $error("fifth bit set early");

endmodule

// File: src_phase_model.sv
// Model of the phase-two clock pin as the processor timing logic drives it.
// Assumes the processor clock is the only reference; runs freely after reset.
`timescale 1ns/100ps
module src_phase_model
#(
    parameter int HALF_CYCLES = 4
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output logic      phase_o
);

    logic [3:0] tick_r;

    // Free-running divider; halves of four clocks keep the three-clock minimum with margin
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            tick_r <= 4'h0;
        end
        else
        begin
            tick_r <= (tick_r == 4'(2 * HALF_CYCLES - 1)) ? 4'h0 : tick_r + 4'h1;
        end
    end

    // High in the first half, low in the second; each fall marks one microcycle
    assign phase_o = (tick_r < 4'(HALF_CYCLES));

endmodule

// File: skip_repeat_counter_tb_top.sv
// Self-checking bench for the skip decoder and repeat counter.
// Assumes the phase model paces microcycles; each word is set up well before its step.
`timescale 1ns/100ps
module skip_repeat_counter_tb_top;
    import src_pkg::*;

    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        phase;
    logic [3:0]  skip_field = NO_OPERATION_CODE;
    logic        special = 1'b0;
    logic        sel_counter = 1'b0;
    logic        sel_none = 1'b0;
    logic [15:0] sbus = 16'h0000;
    logic [15:0] tbus = 16'h0001;
    logic        ovf = 1'b0;
    logic        skip_next;
    logic        repeat_active;
    logic [4:0]  sbus_count;
    logic        sbus_count_en;
    logic        microcycle;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    int          passes;

    // 125 MHz processor clock
    always #4 mclk = ~mclk;

    src_phase_model i_src_phase_model (
        .clk_i   (mclk),
        .rst_n_i (rst_n),
        .phase_o (phase)
    );

    src_skip_repeat i_src_skip_repeat (
        .MCLK_I                 (mclk),
        .RST_N_I                (rst_n),
        .SECOND_PHASE_CLOCK_I   (phase),
        .SKIP_FIELD_I           (skip_field),
        .SPECIAL_COUNTER_I      (special),
        .SBUS_SEL_COUNTER_I     (sel_counter),
        .SBUS_SEL_NONE_I        (sel_none),
        .SBUS_I                 (sbus),
        .TBUS_I                 (tbus),
        .OVERFLOW_FLAG_SIGNAL_I (ovf),
        .SKIP_NEXT_O            (skip_next),
        .REPEAT_ACTIVE_O        (repeat_active),
        .SBUS_COUNT_O           (sbus_count),
        .SBUS_COUNT_EN_O        (sbus_count_en),
        .MICROCYCLE_O           (microcycle)
    );

    task automatic give_verdict();
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One microinstruction: present fields, wait for its step, let readback settle
    task automatic micro(input logic [3:0] sk, input logic sp, input logic nn,
                         input logic [15:0] sb, input logic [15:0] tb, input logic ov);
        int n;
        n = 0;
        @(posedge mclk);
        skip_field <= sk;
        special    <= sp;
        sel_none   <= nn;
        sbus       <= sb;
        tbus       <= tb;
        ovf        <= ov;
        @(posedge mclk);
        #1;
        while (microcycle !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("microcycle", {7'h0, microcycle}, 8'h01);
        @(posedge mclk);
        #1;
    endtask

    task automatic res(input string nm, input logic sk, input logic rp, input logic [4:0] c);
        chk({nm, " skip"}, {7'h0, skip_next}, {7'h0, sk});
        chk({nm, " repeat"}, {7'h0, repeat_active}, {7'h0, rp});
        chk({nm, " count"}, {3'h0, sbus_count}, {3'h0, c});
    endtask

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk("reset", {skip_next, repeat_active, sbus_count, sbus_count_en}, 8'h00);
        @(posedge mclk);
        sel_counter <= 1'b1;
        micro(NO_OPERATION_CODE, 1'b1, 1'b0, 16'hfffa, 16'h1, 1'b0);
        res("load", 1'b0, 1'b0, 5'h0a);
        micro(INCREMENT_ONLY_CODE, 1'b0, 1'b0, 16'h0, 16'h0, 1'b0);
        res("inc", 1'b0, 1'b0, 5'h0b);
        micro(NO_OPERATION_CODE, 1'b0, 1'b0, 16'h0, 16'h0, 1'b1);
        res("nop", 1'b0, 1'b0, 5'h0b);
        micro(NO_OPERATION_CODE, 1'b1, 1'b0, 16'h000f, 16'h1, 1'b0);
        micro(COUNT_FULL_SKIP_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        res("full", 1'b1, 1'b0, 5'h0f);
        micro(TEST_INCREMENT_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        res("skipped", 1'b0, 1'b0, 5'h0f);
        micro(TEST_INCREMENT_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        res("test inc", 1'b1, 1'b0, 5'h10);
        micro(NO_OPERATION_CODE, 1'b1, 1'b0, 16'h0003, 16'h1, 1'b0);
        res("inhibited load", 1'b0, 1'b0, 5'h10);
        micro(INCREMENT_ONLY_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        res("fifth kept", 1'b0, 1'b0, 5'h11);
        // Fifth bit set, low bits not full: the test must not fire
        micro(COUNT_FULL_SKIP_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        res("bit4 ignored", 1'b0, 1'b0, 5'h11);
        micro(NO_OPERATION_CODE, 1'b1, 1'b0, 16'h0006, 16'h1, 1'b0);
        res("reload", 1'b0, 1'b0, 5'h06);
        micro(NO_OPERATION_CODE, 1'b1, 1'b1, 16'hffff, 16'h1, 1'b0);
        res("clear", 1'b0, 1'b0, 5'h00);
        // Overflow and zero codes first untaken, then taken; always-skip taken only; each taken skip then a filler word
        micro(OVERFLOW_SKIP_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        res("ovf clear", 1'b0, 1'b0, 5'h00);
        micro(OVERFLOW_SKIP_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b1);
        res("ovf set", 1'b1, 1'b0, 5'h00);
        micro(NO_OPERATION_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        micro(RESULT_ZERO_SKIP_CODE, 1'b0, 1'b0, 16'h0, 16'h8000, 1'b1);
        res("tbus nonzero", 1'b0, 1'b0, 5'h00);
        micro(RESULT_ZERO_SKIP_CODE, 1'b0, 1'b0, 16'h0, 16'h0, 1'b0);
        res("tbus zero", 1'b1, 1'b0, 5'h00);
        micro(NO_OPERATION_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        micro(ALWAYS_SKIP_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        res("always", 1'b1, 1'b0, 5'h00);
        micro(NO_OPERATION_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
        // Multiply pattern: clear and arm repeat, then the step word until the count fills
        micro(REPEAT_MODE_CODE, 1'b1, 1'b1, 16'hffff, 16'h1, 1'b0);
        res("mpy arm", 1'b0, 1'b1, 5'h00);
        passes = 0;
        // Repeated word tests the counter only, never the T-bus
        do
        begin
            micro(TEST_INCREMENT_CODE, 1'b0, 1'b0, 16'h0, 16'h0, 1'b0);
            passes++;
        end
        while (repeat_active === 1'b1 && passes < 20);
        chk("mpy passes", 8'(passes), 8'h10);
        res("mpy end", 1'b0, 1'b0, 5'h10);
        // Shift by five: two's complement of the count, then repeat
        micro(REPEAT_MODE_CODE, 1'b1, 1'b0, 16'hfffb, 16'h1, 1'b0);
        res("shift arm", 1'b0, 1'b1, 5'h0b);
        passes = 0;
        do
        begin
            micro(TEST_INCREMENT_CODE, 1'b0, 1'b0, 16'h0, 16'h1, 1'b0);
            passes++;
        end
        while (repeat_active === 1'b1 && passes < 20);
        chk("shift passes", 8'(passes), 8'h05);
        res("shift end", 1'b0, 1'b0, 5'h10);
        // Readback enable follows the counter select with one clock of lag
        @(posedge mclk);
        sel_counter <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("readback off", {7'h0, sbus_count_en}, 8'h00);
        @(posedge mclk);
        sel_counter <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk("readback on", {2'h0, sbus_count_en, sbus_count}, 8'h30);
        give_verdict();
    end

endmodule
